/* File: sensor_pkg.sv */
// Shared constants, types and helpers for the pressure sensor serial readout.
package sensor_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS  = 20;
  localparam int SS_LOW_MIN_NS  = 8000;
  localparam int SS_LOW_MIN_CYC = (SS_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [8:0] SS_CNT_MAX = 9'(SS_LOW_MIN_CYC);

  // ----------------------------------------
  // Widths, counts and encodings
  // ----------------------------------------
  localparam int BRIDGE_W   = 14;
  localparam int TEMP_W     = 11;
  localparam int PKT_W      = 32;
  localparam int CMD_W      = 24;
  localparam int FIFO_DEPTH = 32;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [1:0] CMD_BYTES     = 2'h3;
  localparam logic [1:0] STATUS_VALID  = 2'h0;
  localparam logic [1:0] STATUS_STALE  = 2'h2;
  localparam logic [4:0] PAD_BITS      = 5'h00;

  // ----------------------------------------
  // Synchronised pin positions and idle levels
  // ----------------------------------------
  localparam int PIN_SCL  = 0;
  localparam int PIN_SDA  = 1;
  localparam int PIN_SCLK = 2;
  localparam int PIN_SS   = 3;
  localparam int PIN_W    = 4;
  localparam logic [3:0] PIN_RST = 4'hb;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_ACK, I_WR, I_RD, I_RD_ACK, I_RD_NEXT
  } i2c_state_t;

  // Byte idx of the packet, most significant first; bytes past the end read zero.
  function automatic logic [7:0] byte_of(input logic [31:0] pkt, input logic [2:0] idx);
    case (idx)
      3'h0:    byte_of = pkt[31:24];
      3'h1:    byte_of = pkt[23:16];
      3'h2:    byte_of = pkt[15:8];
      3'h3:    byte_of = pkt[7:0];
      default: byte_of = 8'h00;
    endcase
  endfunction

endpackage

/* File: fifo_if.sv */
// Valid/ready carrier between the readout core and its command buffer.
`timescale 1ns/1ps
interface fifo_if #(parameter int W = 24);
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport src (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
  modport buf_side (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface

/* File: pin_sync.sv */
// Two-stage synchroniser for a group of pin levels.
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W   = 4,
  parameter logic [3:0] RST = 4'h0
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t n;

  always_comb begin
    n    = s;
    n.s1 = d_in;
    n.s2 = s.s1;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s.s1 <= RST[W-1:0];
      s.s2 <= RST[W-1:0];
    end else begin
      s <= n;
    end
  end

  assign q_out = s.s2;
endmodule

/* File: cmd_fifo.sv */
// Parameterised flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module cmd_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 32
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  fifo_if.buf_side  f
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
  } fifo_state_t;

  fifo_state_t s;
  fifo_state_t n;
  logic        do_push;
  logic        do_pop;

  assign f.push_ready = (s.cnt != FULL_CNT);
  assign f.pop_valid  = (s.cnt != '0);
  assign f.pop_data   = s.mem[s.rp];
  assign do_push      = f.push_valid & f.push_ready;
  assign do_pop       = f.pop_valid & f.pop_ready;

  always_comb begin
    n = s;
    if (do_push) begin
      n.mem[s.wp] = f.push_data;
      n.wp        = s.wp + AW'(1);
    end
    if (do_pop) begin
      n.rp = s.rp + AW'(1);
    end
    case ({do_push, do_pop})
      2'b10:   n.cnt = s.cnt + (AW+1)'(1);
      2'b01:   n.cnt = s.cnt - (AW+1)'(1);
      default: n.cnt = s.cnt;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end
endmodule

/* File: sensor_readout.sv */
// Serial readout core: I2C slave, SPI read-out and measurement request logic.
// ----------------------------------------
// Notes on behaviour
// - I2C read opens with 7-bit address plus read bit; device acknowledges.
// - In sleep, a read request wakes a full temperature, zero and bridge cycle; code does so only while no valid result is held.
// - A two or three byte fetch may act as request; host ignores stale data.
// - Fetch keeps sending bytes until host not-acknowledges and stops.
// - Three bytes: bridge pair with status on top, then temperature high byte.
// - Fourth byte ends 11-bit temperature; its low 5 bits are undefined.
// - SPI output changes on falling or rising edge per polarity bit, falling default.
// - SPI select low at least 8 us then high requests a full measurement.
// - Falling polarity: output changes after SCLK fall, host samples on rise.
// - SPI packet is 32 bits: bridge high, bridge low, T high, T low plus pad.
// - I2C write opens with 7-bit address plus write bit; device acknowledges; code does not while a refused command is pending.
// - In sleep, an I2C write requests a bridge-only measurement with old zero data.
// - Command writes are I2C only: address, command byte, 16-bit data.
// - After a completed fetch, status reads stale until a new result lands.
// - A fetch during a running measurement returns stale status.
// - In I2C mode the shared pin rises when new valid data is ready.
// - Interface select input: zero picks I2C, one picks SPI.
// ----------------------------------------
`timescale 1ns/1ps
module sensor_readout (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic [6:0]  dev_addr_in,
  input  wire logic        spi_sel_in,
  input  wire logic        spi_pol_in,
  input  wire logic        sleep_mode_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  input  wire logic        sclk_in,
  input  wire logic        ss_n_in,
  output logic             int_out,
  output logic             int_oe_n_out,
  output logic             miso_out,
  output logic             miso_oe_n_out,
  input  wire logic        meas_done_in,
  input  wire logic [13:0] bridge_in,
  input  wire logic [10:0] temp_in,
  output logic             meas_start_out,
  output logic             meas_full_out,
  output logic             status_valid_out,
  output logic             cmd_valid_out,
  output logic [23:0]      cmd_word_out,
  input  wire logic        cmd_ready_in
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sensor_pkg::i2c_state_t st;
    logic [3:0]  bcnt;
    logic [7:0]  sh;
    logic        sda_drv;
    logic        rw;
    logic        act;
    logic [2:0]  bidx;
    logic        fetched;
    logic [1:0]  wcnt;
    logic [7:0]  cmd;
    logic [15:0] cdata;
    logic        push;
    logic [3:0]  prev;
    logic [31:0] pkt;
    logic [31:0] sp;
    logic        sfirst;
    logic [3:0]  sbits;
    logic [8:0]  sscnt;
    logic        moe_n;
    logic        valid;
    logic        busy;
    logic [13:0] bridge;
    logic [10:0] temp;
    logic        start;
    logic        full;
    logic        intr;
    logic        ioe_n;
    logic        cmd_v;
    logic [23:0] cmd_out;
  } core_state_t;

  core_state_t s;
  core_state_t n;
  logic [3:0]  pin;
  logic        scl_r, scl_f, sda_r, sda_f, sclk_r, sclk_f, ss_r, ss_f;
  logic        i2c_start, i2c_stop, addr_hit, chg_edge, smp_edge, ss_low;
  logic [31:0] pkt_now;

  fifo_if #(.W(sensor_pkg::CMD_W)) fq ();

  // Pins cross from the host's clocks; nothing reads them before the second stage.
  pin_sync #(.W(sensor_pkg::PIN_W), .RST(sensor_pkg::PIN_RST)) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   ({ss_n_in, sclk_in, sda_in, scl_in}),
    .q_out  (pin)
  );

  cmd_fifo #(.W(sensor_pkg::CMD_W), .DEPTH(sensor_pkg::FIFO_DEPTH)) u_fifo (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .f      (fq)
  );

  // ----------------------------------------
  // Edges and packet
  // ----------------------------------------
  assign scl_r     = pin[sensor_pkg::PIN_SCL] & ~s.prev[sensor_pkg::PIN_SCL];
  assign scl_f     = ~pin[sensor_pkg::PIN_SCL] & s.prev[sensor_pkg::PIN_SCL];
  assign sda_r     = pin[sensor_pkg::PIN_SDA] & ~s.prev[sensor_pkg::PIN_SDA];
  assign sda_f     = ~pin[sensor_pkg::PIN_SDA] & s.prev[sensor_pkg::PIN_SDA];
  assign sclk_r    = pin[sensor_pkg::PIN_SCLK] & ~s.prev[sensor_pkg::PIN_SCLK];
  assign sclk_f    = ~pin[sensor_pkg::PIN_SCLK] & s.prev[sensor_pkg::PIN_SCLK];
  assign ss_r      = pin[sensor_pkg::PIN_SS] & ~s.prev[sensor_pkg::PIN_SS];
  assign ss_f      = ~pin[sensor_pkg::PIN_SS] & s.prev[sensor_pkg::PIN_SS];
  assign ss_low    = ~pin[sensor_pkg::PIN_SS];
  assign i2c_start = ~spi_sel_in & sda_f & pin[sensor_pkg::PIN_SCL];
  assign i2c_stop  = ~spi_sel_in & sda_r & pin[sensor_pkg::PIN_SCL];
  // A pending command that the full buffer refused blocks further writes.
  assign addr_hit  = (s.sh[7:1] == dev_addr_in) & (s.sh[0] | ~s.push);
  assign chg_edge  = spi_pol_in ? sclk_r : sclk_f;
  assign smp_edge  = spi_pol_in ? sclk_f : sclk_r;
  // Status shows stale while a measurement runs or after a fetch.
  assign pkt_now   = {(s.valid & ~s.busy) ? sensor_pkg::STATUS_VALID
                                          : sensor_pkg::STATUS_STALE,
                      s.bridge, s.temp, sensor_pkg::PAD_BITS};
  assign fq.push_valid = s.push;
  assign fq.push_data  = {s.cmd, s.cdata};
  assign fq.pop_ready  = ~s.cmd_v | cmd_ready_in;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n       = s;
    n.start = 1'b0;
    n.prev  = pin;
    if (!spi_sel_in) begin
      if (i2c_start) begin
        n.st      = sensor_pkg::I_ADDR;
        n.bcnt    = 4'h0;
        n.sda_drv = 1'b0;
        n.fetched = 1'b0;
        n.wcnt    = 2'h0;
        n.bidx    = 3'h0;
      end else if (i2c_stop) begin
        if (s.act && s.rw && s.fetched) begin
          n.valid = 1'b0;
        end
        if (s.act && !s.rw && sleep_mode_in && !s.busy) begin
          n.start = 1'b1;
          n.full  = 1'b0;
          n.busy  = 1'b1;
        end
        if (s.act && !s.rw && !sleep_mode_in && s.wcnt == sensor_pkg::CMD_BYTES) begin
          n.push = 1'b1;
        end
        n.st      = sensor_pkg::I_IDLE;
        n.act     = 1'b0;
        n.sda_drv = 1'b0;
      end else begin
        case (s.st)
          sensor_pkg::I_ADDR, sensor_pkg::I_WR: begin
            if (scl_r) begin
              n.sh   = {s.sh[6:0], pin[sensor_pkg::PIN_SDA]};
              n.bcnt = s.bcnt + 4'h1;
            end else if (scl_f && s.bcnt == sensor_pkg::BITS_PER_BYTE) begin
              n.st      = sensor_pkg::I_ACK;
              n.sda_drv = 1'b1;
              if (s.st == sensor_pkg::I_WR) begin
                case (s.wcnt)
                  2'h0:    n.cmd         = s.sh;
                  2'h1:    n.cdata[15:8] = s.sh;
                  2'h2:    n.cdata[7:0]  = s.sh;
                  default: n.cmd         = s.cmd;
                endcase
                if (s.wcnt != sensor_pkg::CMD_BYTES) begin
                  n.wcnt = s.wcnt + 2'h1;
                end
              end else if (addr_hit) begin
                n.rw  = s.sh[0];
                n.act = 1'b1;
                n.pkt = pkt_now;
                if (s.sh[0] && sleep_mode_in && !s.valid && !s.busy) begin
                  n.start = 1'b1;
                  n.full  = 1'b1;
                  n.busy  = 1'b1;
                end
              end else begin
                n.st      = sensor_pkg::I_IDLE;
                n.sda_drv = 1'b0;
              end
            end
          end
          sensor_pkg::I_ACK, sensor_pkg::I_RD_NEXT: begin
            if (scl_f) begin
              if (s.rw) begin
                n.sh      = sensor_pkg::byte_of(s.pkt, s.bidx);
                n.sda_drv = ~n.sh[7];
                n.bidx    = (s.bidx == 3'h7) ? s.bidx : s.bidx + 3'h1;
                n.bcnt    = 4'h1;
                n.st      = sensor_pkg::I_RD;
              end else begin
                n.sda_drv = 1'b0;
                n.bcnt    = 4'h0;
                n.st      = sensor_pkg::I_WR;
              end
            end
          end
          sensor_pkg::I_RD: begin
            if (scl_f) begin
              if (s.bcnt == sensor_pkg::BITS_PER_BYTE) begin
                n.sda_drv = 1'b0;
                n.st      = sensor_pkg::I_RD_ACK;
              end else begin
                n.sh      = {s.sh[6:0], 1'b0};
                n.sda_drv = ~s.sh[6];
                n.bcnt    = s.bcnt + 4'h1;
              end
            end
          end
          sensor_pkg::I_RD_ACK: begin
            if (scl_r) begin
              n.fetched = 1'b1;
              n.st = pin[sensor_pkg::PIN_SDA] ? sensor_pkg::I_IDLE
                                              : sensor_pkg::I_RD_NEXT;
            end
          end
          sensor_pkg::I_IDLE: n.st = sensor_pkg::I_IDLE;
          default:            n.st = sensor_pkg::I_IDLE;
        endcase
      end
    end else begin
      if (ss_f) begin
        n.sp     = pkt_now;
        n.sfirst = 1'b1;
        n.sbits  = 4'h0;
        n.sscnt  = 9'h0;
      end else if (ss_low) begin
        if (s.sscnt != sensor_pkg::SS_CNT_MAX) begin
          n.sscnt = s.sscnt + 9'h1;
        end
        if (chg_edge) begin
          // Rising polarity keeps the first bit, loaded at select, through the first rise; shifting starts at the second rise.
          if (spi_pol_in && s.sfirst) begin
            n.sfirst = 1'b0;
          end else begin
            n.sp = {s.sp[30:0], 1'b0};
          end
        end
        if (smp_edge && s.sbits != sensor_pkg::BITS_PER_BYTE) begin
          n.sbits = s.sbits + 4'h1;
        end
      end else if (ss_r) begin
        if (s.sbits == 4'h0 && s.sscnt == sensor_pkg::SS_CNT_MAX && sleep_mode_in
            && !s.busy) begin
          n.start = 1'b1;
          n.full  = 1'b1;
          n.busy  = 1'b1;
        end
        if (s.sbits == sensor_pkg::BITS_PER_BYTE) begin
          n.valid = 1'b0;
        end
      end
    end
    // A result arriving with a fetch's clear wins over the clear.
    if (meas_done_in) begin
      n.busy   = 1'b0;
      n.valid  = 1'b1;
      n.bridge = bridge_in;
      n.temp   = temp_in;
    end
    n.moe_n = ~(spi_sel_in & ss_low);
    n.ioe_n = spi_sel_in;
    n.intr  = n.valid & ~n.busy;
    if (s.push && fq.push_ready) begin
      n.push = 1'b0;
    end
    if (i2c_stop && s.act && !s.rw && !sleep_mode_in && s.wcnt == sensor_pkg::CMD_BYTES) begin
      n.push = 1'b1;
    end
    if (s.cmd_v && cmd_ready_in) begin
      n.cmd_v = 1'b0;
    end
    if (fq.pop_valid && fq.pop_ready) begin
      n.cmd_v   = 1'b1;
      n.cmd_out = fq.pop_data;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s       <= '0;
      s.prev  <= sensor_pkg::PIN_RST;
      s.moe_n <= 1'b1;
      s.ioe_n <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // SDA is open drain: only the enable moves, the driven level is always low.
  assign sda_out          = 1'b0;
  assign sda_oe_n_out     = ~s.sda_drv;
  assign int_out          = s.intr;
  assign int_oe_n_out     = s.ioe_n;
  assign miso_out         = s.sp[31];
  assign miso_oe_n_out    = s.moe_n;
  assign meas_start_out   = s.start;
  assign meas_full_out    = s.full;
  assign status_valid_out = s.valid;
  assign cmd_valid_out    = s.cmd_v;
  assign cmd_word_out     = s.cmd_out;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence addr_byte_done;
    !spi_sel_in && s.st == sensor_pkg::I_ADDR && scl_f && s.bcnt == sensor_pkg::BITS_PER_BYTE;
  endsequence

  sequence ss_long_pulse;
    spi_sel_in && ss_r && s.sbits == 4'h0 && s.sscnt == sensor_pkg::SS_CNT_MAX;
  endsequence

  a_addr_ack: assert property (addr_byte_done ##0 addr_hit |=> s.st == sensor_pkg::I_ACK
    && !sda_oe_n_out) else $error("address byte not acknowledged");
  a_read_wake: assert property (addr_byte_done ##0 (addr_hit && s.sh[0] && sleep_mode_in
    && !s.valid && !s.busy) |=> meas_start_out && meas_full_out)
    else $error("read request did not start a full cycle");
  a_nack_end: assert property (!spi_sel_in && s.st == sensor_pkg::I_RD_ACK && scl_r
    && pin[sensor_pkg::PIN_SDA] && !i2c_stop |=> s.st == sensor_pkg::I_IDLE && sda_oe_n_out)
    else $error("fetch continued after not-acknowledge");
  a_fetch_stale: assert property (i2c_stop && s.act && s.rw && s.fetched && !meas_done_in
    |=> !status_valid_out) else $error("status not stale after fetch");
  a_busy_stale: assert property (addr_byte_done ##0 (addr_hit && s.busy)
    |=> s.pkt[31:30] == sensor_pkg::STATUS_STALE) else $error("busy packet not stale");
  a_int_rise: assert property (!spi_sel_in && meas_done_in |=> int_out && !int_oe_n_out)
    else $error("interrupt did not rise on new data");
  a_spi_wake: assert property (ss_long_pulse ##0 (sleep_mode_in && !s.busy)
    |=> meas_start_out && meas_full_out) else $error("select pulse ignored");
  a_spi_short: assert property (spi_sel_in && ss_r && s.sscnt != sensor_pkg::SS_CNT_MAX
    |=> !meas_start_out) else $error("short select pulse woke device");
  a_bridge_wake: assert property (i2c_stop && s.act && !s.rw && sleep_mode_in && !s.busy
    |=> meas_start_out && !meas_full_out ##1 !meas_start_out)
    else $error("write did not start bridge-only cycle");
  a_miso_first: assert property (spi_sel_in && ss_f |=> miso_out == $past(pkt_now[31])
    && !miso_oe_n_out) else $error("packet not loaded at select");
  a_cmd_push: assert property (i2c_stop && s.act && !s.rw && !sleep_mode_in
    && s.wcnt == sensor_pkg::CMD_BYTES |=> fq.push_valid)
    else $error("command not queued");
endmodule

/* File: host_model.sv */
// Host master model that drives the I2C and SPI pins of the sensor readout.
`timescale 1ns/1ps
module host_model (
  input  wire logic clk_in,
  input  wire logic sda_in,
  input  wire logic miso_in,
  output logic      scl_out,
  output logic      sda_out,
  output logic      sclk_out,
  output logic      ss_n_out
);
  // ----
  // Idle levels
  // ----
  // SCLK stands low between frames. A released SDA is left to the pull-up.
  initial begin
    scl_out  = 1'b1;
    sda_out  = 1'b1;
    sclk_out = 1'b0;
    ss_n_out = 1'b1;
  end
  // ----
  // Link tasks
  // ----
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic start_c();
    tick(4);
    sda_out = 1'b0;
    tick(4);
    scl_out = 1'b0;
  endtask
  task automatic stop_c();
    tick(3);
    sda_out = 1'b0;
    tick(1);
    scl_out = 1'b1;
    tick(4);
    sda_out = 1'b1;
    tick(8);
  endtask
  // SDA moves 3 cycles after SCL falls, so the device's synchroniser never sees it race SCL.
  task automatic bit_x(input logic b, output logic r);
    tick(3);
    sda_out = b;
    tick(1);
    scl_out = 1'b1;
    tick(4);
    r = sda_in;
    scl_out = 1'b0;
  endtask
  // Eight bits MSB first, then the acknowledge slot; a one there releases it.
  task automatic byte_x(input logic [7:0] b, input logic a_in, output logic [7:0] r,
                        output logic a);
    for (int i = 7; i >= 0; i--) bit_x(b[i], r[i]);
    bit_x(a_in, a);
  endtask
  task automatic ss_hold(input int n);
    ss_n_out = 1'b0;
    tick(n);
    ss_n_out = 1'b1;
    tick(8);
  endtask
  task automatic spi_read(input logic pol, input int n, output logic [31:0] d);
    d = '0;
    ss_n_out = 1'b0;
    tick(8);
    for (int i = 31; i > 31 - n; i--) begin
      if (!pol) d[i] = miso_in;
      sclk_out = 1'b1;
      tick(4);
      if (pol) d[i] = miso_in;
      sclk_out = 1'b0;
      tick(4);
    end
    ss_n_out = 1'b1;
    tick(8);
  endtask
endmodule

/* File: tb.sv */
// Self-checking testbench for the pressure sensor serial readout.
`timescale 1ns/1ps
module tb;
  localparam logic [6:0] ADDR = 7'h28;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        spi_sel = 1'b0, spi_pol = 1'b0, sleep = 1'b1, done = 1'b0, rdy = 1'b0;
  logic [13:0] bridge = '0;
  logic [10:0] temp = '0;
  logic        scl, sda_h, sclk, ss_n, sda_o, sda_oe_n, int_o, int_oe_n, miso, miso_oe_n;
  logic        start, full, valid, cmd_valid;
  logic        full_seen = 1'b0;
  logic [23:0] cmd_word;
  wire         sda_w = sda_h & (sda_oe_n | sda_o);
  wire         pin_ss = int_oe_n ? ss_n : int_o;
  // A released MISO shows the inverse of its last bit, so a sample taken too early is caught.
  wire         miso_w = miso_oe_n ? ~miso : miso;
  int          miscompares = 0, checked = 0, starts = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  sensor_readout DUT (.clk_in(clk_in), .rst_in(rst_in), .dev_addr_in(ADDR),
    .spi_sel_in(spi_sel), .spi_pol_in(spi_pol), .sleep_mode_in(sleep), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .sclk_in(sclk),
    .ss_n_in(pin_ss), .int_out(int_o), .int_oe_n_out(int_oe_n), .miso_out(miso),
    .miso_oe_n_out(miso_oe_n), .meas_done_in(done), .bridge_in(bridge), .temp_in(temp),
    .meas_start_out(start), .meas_full_out(full), .status_valid_out(valid),
    .cmd_valid_out(cmd_valid), .cmd_word_out(cmd_word), .cmd_ready_in(rdy));
  host_model h (.clk_in(clk_in), .sda_in(sda_w), .miso_in(miso_w), .scl_out(scl),
    .sda_out(sda_h), .sclk_out(sclk), .ss_n_out(ss_n));
  // ----
  // Monitors and helpers
  // ----
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (start === 1'b1) begin
      starts <= starts + 1;
      full_seen <= full;
    end
  end
  always @(negedge clk_in) if (cyc >= 60000) begin
    miscompares++;
    final_report();
  end
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic meas(input logic [13:0] b, input logic [10:0] t);
    @(negedge clk_in);
    bridge = b;
    temp = t;
    done = 1'b1;
    @(negedge clk_in);
    done = 1'b0;
    @(negedge clk_in);
    chk("valid", 1, valid);
    if (!spi_sel) chk("int", 1, int_o);
  endtask
  task automatic rd(input logic [6:0] a, input int n, output logic [31:0] d, output logic ack);
    logic [7:0] r;
    logic       x;
    d = '0;
    h.start_c();
    h.byte_x({a, 1'b1}, 1'b1, r, ack);
    for (int i = 0; i < n; i++) begin
      h.byte_x(8'hff, i == n - 1, r, x);
      d[31 - 8 * i -: 8] = r;
    end
    h.stop_c();
  endtask
  task automatic wr(input int n, input logic [23:0] w, output logic ack);
    logic [7:0] r;
    logic       x;
    h.start_c();
    h.byte_x({ADDR, 1'b0}, 1'b1, r, ack);
    for (int i = 0; i < n; i++) h.byte_x(w[23 - 8 * i -: 8], 1'b1, r, x);
    h.stop_c();
  endtask
  // ----
  // Scenarios
  // ----
  task automatic s_fetch();
    logic [31:0] d;
    logic        ack;
    int          s0;
    s0 = starts;
    rd(ADDR, 0, d, ack);
    chk("ack", 0, ack);
    chk("starts", s0 + 1, starts);
    chk("full", 1, full_seen);
    rd(ADDR ^ 7'h01, 0, d, ack);
    chk("bad_ack", 1, ack);
    meas(14'h2a5c, 11'h5b3);
    rd(ADDR, 4, d, ack);
    // The low five bits are undefined, so they are masked before comparing.
    chk("pkt4", {2'b00, 14'h2a5c, 11'h5b3, 5'h00}, d & 32'hffff_ffe0);
    chk("valid", 0, valid);
    rd(ADDR, 2, d, ack);
    chk("pkt2", {2'b10, 14'h2a5c}, d[31:16]);
    chk("starts", s0 + 2, starts);
    rd(ADDR, 3, d, ack);
    chk("busy", 2'b10, d[31:30]);
    chk("starts", s0 + 2, starts);
    meas(14'h1337, 11'h0c9);
    rd(ADDR, 3, d, ack);
    chk("pkt3", {2'b00, 14'h1337, 8'h19}, d[31:8]);
  endtask
  task automatic s_write();
    logic ack;
    int   s0;
    for (int n = 0; n < 3; n += 2) begin
      s0 = starts;
      wr(n, 24'h0, ack);
      chk("ack", 0, ack);
      chk("starts", s0 + 1, starts);
      chk("full", 0, full_seen);
      meas(14'h0abc, 11'h123);
    end
  endtask
  // Output word, full buffer and one pending command are accepted before a refusal; then drain.
  task automatic s_cmd();
    logic       ack;
    logic [7:0] k;
    int         n;
    @(negedge clk_in);
    sleep = 1'b0;
    n = 0;
    ack = 1'b0;
    while (ack === 1'b0 && n < 40) begin
      k = n[7:0];
      wr(3, {k, ~k, 8'h00}, ack);
      if (ack === 1'b0) n++;
    end
    chk("accepted", sensor_pkg::FIFO_DEPTH + 2, n);
    for (int j = 0; j < n; j++) begin
      k = j[7:0];
      repeat (100) if (cmd_valid !== 1'b1) @(negedge clk_in);
      chk("cmd_word", {k, ~k, 8'h00}, cmd_word);
      rdy = 1'b1;
      @(negedge clk_in);
      rdy = 1'b0;
      repeat (2) @(negedge clk_in);
    end
    repeat (8) @(negedge clk_in);
    chk("drained", 0, cmd_valid);
    wr(3, 24'h0, ack);
    chk("ack", 0, ack);
    sleep = 1'b1;
  endtask
  task automatic s_spi();
    logic [31:0] d;
    int          s0;
    spi_sel = 1'b1;
    repeat (4) @(negedge clk_in);
    chk("int_oe_n", 1, int_oe_n);
    h.spi_read(1'b0, 32, d);
    chk("spi32", {2'b00, 14'h0abc, 11'h123, 5'h0}, d & 32'hffff_ffe0);
    chk("valid", 0, valid);
    chk("miso_oe_n", 1, miso_oe_n);
    s0 = starts;
    h.ss_hold(300);
    chk("starts", s0, starts);
    h.ss_hold(410);
    chk("starts", s0 + 1, starts);
    chk("full", 1, full_seen);
    meas(14'h3fc1, 11'h7f0);
    spi_pol = 1'b1;
    h.spi_read(1'b1, 24, d);
    chk("spi24", {2'b00, 14'h3fc1, 8'hfe}, d[31:8]);
    chk("valid", 0, valid);
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    rst_in = 1'b0;
    repeat (4) @(negedge clk_in);
    chk("int_oe_n", 0, int_oe_n);
    s_fetch();
    s_write();
    s_cmd();
    s_spi();
    final_report();
  end
endmodule
